// file: dv/program_space_address_mapper_bench.sv
`default_nettype none
module program_space_address_mapper_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import psmap_pkg::*;
   logic hclk;
   logic hresetn;
   logic [31:0] haddr;
   logic [1:0] htrans;
   logic hwrite;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   core_req_s req;
   logic [23:0] prog_rdata;
   map_rsp_s rsp;
   logic [31:0] rd;
   int error_cnt;
   int check_count;
   psmap_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .req(req),
      .prog_rdata(prog_rdata), .rsp(rsp));
   psmap_flash flash_u (.valid(rsp.valid), .addr(rsp.addr), .rdata(prog_rdata));
////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] s, input logic [31:0] e, input string n);
      check_count++;
      if (s !== e) begin
         error_cnt++;
         $display("mismatch %s exp %h seen %h", n, e, s);
      end
   endtask
   task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge hclk);
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   // One-cycle request, answer settled just after the next edge
   task automatic go(input core_req_s v);
      @(posedge hclk);
      req <= v;
      @(posedge hclk);
      req <= '0;
      #1;
   endtask
   task automatic t_regs;
      bus(1'b0, 32'h0000_0040, 32'h0);
      chk(rd, 32'h0, "unmapped");
      chk(32'(hresp), 32'h0, "okay resp");
      // Idle request: source none in bits 11:8, all flags clear
      bus(1'b0, ADDR_STATUS, 32'h0);
      chk(rd, 32'h0000_0100, "idle status");
      bus(1'b1, ADDR_TBL_PAGE, 32'h85);
      bus(1'b0, ADDR_TBL_PAGE, 32'h0);
      chk(rd, 32'h85, "tbl page");
   endtask
   task automatic t_fetch;
      go('{fetch: 1'b1, pc: 24'hff_ffff, default: '0});
      chk(32'(rsp.addr), 32'h7f_fffe, "fetch addr");
   endtask
   task automatic t_table;
      go('{tbl_rd: 1'b1, data_rd: 1'b1, ea: 16'h8234, default: '0});
      chk(32'(rsp.addr), 32'h85_8234, "tbl addr");
      chk(32'(rsp.cfg_sel), 32'h1, "cfg sel");
      bus(1'b1, ADDR_TBL_PAGE, 32'h05);
      go('{tbl_wr: 1'b1, ea: 16'hffff, default: '0});
      chk(32'({rsp.cfg_sel, rsp.wr, rsp.addr}), 32'h105_ffff, "user wr");
   endtask
   task automatic t_window;
      go('{data_rd: 1'b1, ea: 16'h8004, is_move: 1'b1, default: '0});
      chk(32'({rsp.to_data_mem, rsp.extra_cycles}), 32'h4, "win off");
      bus(1'b1, ADDR_VIS_PAGE, 32'h3d);
      bus(1'b1, ADDR_CORE_CTRL, 32'h4);
      // Enable now set, so a table op must hold the window off
      go('{tbl_rd: 1'b1, data_rd: 1'b1, ea: 16'h8010, default: '0});
      chk(32'({rsp.win_refused, rsp.valid, rsp.addr}), 32'h305_8010, "win held");
      go('{data_rd: 1'b1, ea: 16'h8004, is_move: 1'b1, default: '0});
      chk(32'(rsp.addr), {9'h0, 8'h3d, 15'h0004}, "win addr");
      chk(32'(rsp.extra_cycles), 32'h1, "move extra");
      @(posedge hclk);
      #1;
      // Odd page puts a one in program address bit 15
      chk(32'(rsp.win_data), 32'h8004 ^ 32'ha5c3, "win data");
      bus(1'b1, ADDR_VIS_PAGE, 32'hff);
      go('{data_rd: 1'b1, ea: 16'hffff, default: '0});
      chk(32'(rsp.addr), 32'h7f_ffff, "top page");
      chk(32'(rsp.extra_cycles), 32'h2, "other extra");
      go('{data_rd: 1'b1, ea: 16'h7fff, default: '0});
      chk(32'({rsp.to_data_mem, rsp.extra_cycles}), 32'h4, "low half");
      go('{data_wr: 1'b1, ea: 16'h8000, default: '0});
      chk(32'({rsp.win_refused, rsp.valid}), 32'h2, "win write");
   endtask
   // Move set so a plain one-cycle answer cannot hide a wrong repeat case
   task automatic t_repeat;
      core_req_s v;
      for (int i = 0; i < 5; i++) begin
         v = '{data_rd: 1'b1, ea: 16'h8010, is_move: 1'b1, in_repeat: 1'b1, default: '0};
         {v.rpt_first, v.rpt_last, v.rpt_irq_exit, v.rpt_irq_reentry} = 4'h8 >> i;
         go(v);
         chk(32'(rsp.extra_cycles), (i < 4) ? 32'h2 : 32'h1, "repeat extra");
      end
   endtask
   task automatic complete_run;
      if (error_cnt == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   initial begin
      hclk = 1'b0;
      forever #4 hclk = ~hclk;
   end
   initial begin
      hresetn = 1'b0;
      haddr = '0;
      htrans = '0;
      hwrite = 1'b0;
      hwdata = '0;
      req = '0;
      error_cnt = 0;
      check_count = 0;
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      t_regs;
      t_fetch;
      t_table;
      t_window;
      t_repeat;
      complete_run;
   end
   // About 63 cycles expected; generous margin
   initial begin
      #20000;
      error_cnt++;
      complete_run;
   end
endmodule // program_space_address_mapper_bench
`default_nettype wire

// file: dv/psmap_asserts.sv
`default_nettype none
module psmap_asserts (
   input wire logic hclk,
   input wire logic hresetn,
   input wire psmap_pkg::core_req_s req,
   input wire logic [23:0] prog_rdata,
   input wire psmap_pkg::map_rsp_s rsp
);
   timeunit 1ns;
   timeprecision 1ps;
   import psmap_pkg::*;
   logic nf;
   logic win;
   logic rpt2;
   // Only requests no higher source preempts
   assign nf = !req.fetch && !req.tbl_rd && !req.tbl_wr;
   assign win = nf && req.data_rd && req.ea[15];
   assign rpt2 = req.rpt_first | req.rpt_last | req.rpt_irq_exit | req.rpt_irq_reentry;
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   property p_fetch; req.fetch |=> rsp.addr == {1'b0, $past(req.pc[22:1]), 1'b0}; endproperty
   a_fetch: assert property (p_fetch) else $error("fetch address wrong");
   property p_tbl; !req.fetch && (req.tbl_rd || req.tbl_wr) |=>
      rsp.addr[15:0] == $past(req.ea) && rsp.cfg_sel == rsp.addr[23]; endproperty
   a_tbl: assert property (p_tbl) else $error("table address wrong");
   // Enable is not visible here, so the data-memory answer marks it off
   property p_win; win ##1 !rsp.to_data_mem |->
      !rsp.addr[23] && rsp.addr[14:0] == $past(req.ea[14:0]); endproperty
   a_win: assert property (p_win) else $error("window address wrong");
   property p_wr; nf && req.data_wr && req.ea[15] ##1 !rsp.to_data_mem |->
      rsp.win_refused && !rsp.valid; endproperty
   a_wr: assert property (p_wr) else $error("window write accepted");
   property p_dm; nf && req.data_rd && !req.ea[15] |=>
      rsp.to_data_mem && rsp.extra_cycles == XTRA_NONE; endproperty
   a_dm: assert property (p_dm) else $error("data access wrong");
   property p_x14; win && !req.in_repeat ##1 !rsp.to_data_mem |->
      rsp.extra_cycles == ($past(req.is_move) ? XTRA_ONE : XTRA_TWO); endproperty
   a_x14: assert property (p_x14) else $error("extra cycles wrong");
   property p_x15; win && req.in_repeat && rpt2 ##1 !rsp.to_data_mem |->
      rsp.extra_cycles == XTRA_TWO; endproperty
   a_x15: assert property (p_x15) else $error("repeat edge extra wrong");
   property p_x15b; win && req.in_repeat && !rpt2 ##1 !rsp.to_data_mem |->
      rsp.extra_cycles == XTRA_ONE; endproperty
   a_x15b: assert property (p_x15b) else $error("repeat body extra wrong");
   property p_wd; win ##1 rsp.valid && !rsp.to_data_mem |=>
      rsp.win_data == $past(prog_rdata[15:0]); endproperty
   a_wd: assert property (p_wd) else $error("window data wrong");
endmodule // psmap_asserts
bind psmap_top psmap_asserts chk_u (.hclk(hclk), .hresetn(hresetn), .req(req),
   .prog_rdata(prog_rdata), .rsp(rsp));
`default_nettype wire

// file: dv/psmap_flash.sv
`default_nettype none
module psmap_flash (
   input wire logic valid,
   input wire logic [23:0] addr,
   output logic [23:0] rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   // upper byte all ones; idle bus inverts so stale data never matches
   assign rdata = {24{~valid}} ^ {8'hff, addr[15:0] ^ 16'ha5c3};
endmodule // psmap_flash
`default_nettype wire

// file: rtl/psmap_pkg.sv
// Behaviour
// [R1] Table address is table page above the 16-bit effective address, 24 bits.
// [R2] Table page top bit picks user (0) or configuration (1) memory.
// [R3] Window address is visibility page above effective address bits 14:0.
// [R4] Window used only when effective address bit 15 and enable bit 2 set.
// [R5] Window address bit 23 is always zero.
// [R6] Window address bit 15 comes from visibility page bit 0.
// [R7] Fetch address is program counter with bits 23 and 0 cleared.
// [R8] Visibility page selects one of 256 pages of 32K words.
// [R9] Window covers data addresses 8000h upward.
// [R10] Low 15 data address bits map straight onto program address.
// [R11] Window read returns only low 16 bits of program word.
// [R12] Window is read-only; table accesses reach every byte.
// [R13] Window read adds a cycle for the second program fetch.
// [R14] Outside repeat: one extra for moves, two for others.
// [R15] Repeat: two extra first, last, interrupt exit and re-entry, else one.
// [R16] Window suspended while a table read or write runs.
// [R17] Software should fill upper byte of constant words with all ones or zeros.
// [R18] Otherwise access goes to data memory with no extra cycles.
`default_nettype none
package psmap_pkg;
   localparam logic [31:0] ADDR_CORE_CTRL = 32'h0000_0000;
   localparam logic [31:0] ADDR_TBL_PAGE = 32'h0000_0004;
   localparam logic [31:0] ADDR_VIS_PAGE = 32'h0000_0008;
   localparam logic [31:0] ADDR_STATUS = 32'h0000_000c;
   localparam int VIS_EN_BIT = 2;
   localparam int CFG_SEL_BIT = 7;
   localparam logic [7:0] TBL_PAGE_RST = 8'h00;
   localparam logic [7:0] VIS_PAGE_RST = 8'h00;
   localparam logic [15:0] CORE_CTRL_RST = 16'h0000;
   localparam logic [1:0] XTRA_NONE = 2'h0;
   localparam logic [1:0] XTRA_ONE = 2'h1;
   localparam logic [1:0] XTRA_TWO = 2'h2;

   typedef enum logic [3:0] {
      SRC_NONE = 4'h1,
      SRC_FETCH = 4'h2,
      SRC_TABLE = 4'h4,
      SRC_WINDOW = 4'h8
   } src_e;

   typedef struct packed {
      logic fetch;
      logic [23:0] pc;
      logic data_rd;
      logic data_wr;
      logic [15:0] ea;
      logic tbl_rd;
      logic tbl_wr;
      logic is_move;
      logic in_repeat;
      logic rpt_first;
      logic rpt_last;
      logic rpt_irq_exit;
      logic rpt_irq_reentry;
   } core_req_s;

   typedef struct packed {
      logic valid;
      logic [23:0] addr;
      logic cfg_sel;
      logic wr;
      logic to_data_mem;
      logic [15:0] win_data;
      logic [1:0] extra_cycles;
      logic win_refused;
   } map_rsp_s;
endpackage
`default_nettype wire

// file: rtl/psmap_regs.sv
`default_nettype none
module psmap_regs (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] status_in,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   output logic [15:0] core_ctrl_q,
   output logic [7:0] tbl_page_q,
   output logic [7:0] vis_page_q
);
   import psmap_pkg::*;
   logic wr_pend_q;
   logic [31:0] wr_addr_q;
   logic take;
   logic [15:0] core_ctrl_now;
   logic [7:0] tbl_page_now;
   logic [7:0] vis_page_now;
   assign take = hsel && hready && htrans[1];

   // Write still in its data phase is forwarded, else a read right behind it is stale
   always_comb begin
      core_ctrl_now = core_ctrl_q;
      tbl_page_now = tbl_page_q;
      vis_page_now = vis_page_q;
      if (wr_pend_q) begin
         if (wr_addr_q == ADDR_CORE_CTRL) begin
            core_ctrl_now = hwdata[15:0];
         end else if (wr_addr_q == ADDR_TBL_PAGE) begin
            tbl_page_now = hwdata[7:0];
         end else if (wr_addr_q == ADDR_VIS_PAGE) begin
            vis_page_now = hwdata[7:0];
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 32'h0000_0000;
      end else begin
         wr_pend_q <= take && hwrite;
         if (take) begin
            wr_addr_q <= haddr;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         core_ctrl_q <= CORE_CTRL_RST;
         tbl_page_q <= TBL_PAGE_RST;
         vis_page_q <= VIS_PAGE_RST;
      end else if (wr_pend_q) begin
         if (wr_addr_q == ADDR_CORE_CTRL) begin
            core_ctrl_q <= hwdata[15:0];
         end else if (wr_addr_q == ADDR_TBL_PAGE) begin
            tbl_page_q <= hwdata[7:0];
         end else if (wr_addr_q == ADDR_VIS_PAGE) begin
            vis_page_q <= hwdata[7:0];
         end
      end
   end

   // Read data registered in the address phase, ready a cycle later
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (take && !hwrite) begin
         if (haddr == ADDR_CORE_CTRL) begin
            hrdata <= {16'h0000, core_ctrl_now};
         end else if (haddr == ADDR_TBL_PAGE) begin
            hrdata <= {24'h000000, tbl_page_now};
         end else if (haddr == ADDR_VIS_PAGE) begin
            hrdata <= {24'h000000, vis_page_now};
         end else if (haddr == ADDR_STATUS) begin
            hrdata <= status_in;
         end else begin
            hrdata <= 32'h0000_0000;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   logic unused;
   assign unused = ^hsize;
endmodule // psmap_regs
`default_nettype wire

// file: rtl/psmap_top.sv
`default_nettype none
module psmap_top (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire psmap_pkg::core_req_s req,
   input wire logic [23:0] prog_rdata,
   output psmap_pkg::map_rsp_s rsp
);
   import psmap_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   logic [15:0] core_ctrl_q;
   logic [7:0] tbl_page_q;
   logic [7:0] vis_page_q;
   logic [31:0] status_w;
   src_e src_d;
   src_e src_q;
   map_rsp_s rsp_d;
   logic win_hit;
   logic tbl_busy;

   psmap_regs u_regs (
      .hclk(hclk),
      .hresetn(hresetn),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(hsize),
      .hwdata(hwdata),
      .hready(hready),
      .status_in(status_w),
      .hrdata(hrdata),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .core_ctrl_q(core_ctrl_q),
      .tbl_page_q(tbl_page_q),
      .vis_page_q(vis_page_q)
   );

   ////////////////////////////////////////////////////////////////////////
   assign tbl_busy = req.tbl_rd || req.tbl_wr;
   // [R4] [R9] window decode
   assign win_hit = req.ea[15] && core_ctrl_q[VIS_EN_BIT];
   assign status_w = {20'h00000, src_q, rsp.extra_cycles, rsp.cfg_sel, rsp.win_refused,
                      2'h0, tbl_busy, win_hit};

   always_comb begin
      rsp_d = '0;
      src_d = SRC_NONE;
      if (req.fetch) begin
         // [R7] fetch address
         src_d = SRC_FETCH;
         rsp_d.valid = 1'b1;
         rsp_d.addr = {1'b0, req.pc[22:1], 1'b0};
      end else if (tbl_busy) begin
         // [R1] [R2] [R12] table address and space
         src_d = SRC_TABLE;
         rsp_d.valid = 1'b1;
         rsp_d.addr = {tbl_page_q, req.ea};
         rsp_d.cfg_sel = tbl_page_q[CFG_SEL_BIT];
         rsp_d.wr = req.tbl_wr;
         // [R16] window held off
         rsp_d.win_refused = win_hit && (req.data_rd || req.data_wr);
      end else if (win_hit && req.data_wr) begin
         // [R12] window writes refused
         rsp_d.win_refused = 1'b1;
      end else if (win_hit && req.data_rd) begin
         // [R3] [R5] [R6] [R8] [R10] window address
         src_d = SRC_WINDOW;
         rsp_d.valid = 1'b1;
         rsp_d.addr = {1'b0, vis_page_q, req.ea[14:0]};
         // [R13] [R14] [R15] extra cycles
         if (req.in_repeat) begin
            if (req.rpt_first || req.rpt_last || req.rpt_irq_exit || req.rpt_irq_reentry) begin
               rsp_d.extra_cycles = XTRA_TWO;
            end else begin
               rsp_d.extra_cycles = XTRA_ONE;
            end
         end else if (req.is_move) begin
            rsp_d.extra_cycles = XTRA_ONE;
         end else begin
            rsp_d.extra_cycles = XTRA_TWO;
         end
      end else if (req.data_rd || req.data_wr) begin
         // [R18] ordinary data memory
         rsp_d.to_data_mem = 1'b1;
         rsp_d.extra_cycles = XTRA_NONE;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rsp <= '0;
         src_q <= SRC_NONE;
      end else begin
         rsp.valid <= rsp_d.valid;
         rsp.addr <= rsp_d.addr;
         rsp.cfg_sel <= rsp_d.cfg_sel;
         rsp.wr <= rsp_d.wr;
         rsp.to_data_mem <= rsp_d.to_data_mem;
         rsp.extra_cycles <= rsp_d.extra_cycles;
         rsp.win_refused <= rsp_d.win_refused;
         src_q <= src_d;
         // [R11] low word only of the fetched program word
         if (src_q == SRC_WINDOW) begin
            rsp.win_data <= prog_rdata[15:0];
         end
      end
   end
endmodule // psmap_top
`default_nettype wire
